// *** rtl/sto_pkg.sv ***
package sto_pkg;
	// clock and test pulse timing
	localparam int CLK_HZ = 10000000;
	localparam int TEST_PULSE_US = 1000;
	// least time beyond test pulse, rounded up in cycles
	localparam int FILT_CYCLES = (TEST_PULSE_US * (CLK_HZ / 1000000)) + 1;
	localparam int FILT_W = 14;
	// reset values
	localparam logic RST_SHUTOFF = 1'b1;
	localparam logic RST_ALARM = 1'b0;

	typedef struct packed {
		logic input_a;
		logic input_b;
	} sto_in_t;

	typedef struct packed {
		logic mon_a;
		logic mon_b;
		logic mon_both;
	} sto_mon_t;
endpackage

// *** rtl/sto_filter.sv ***
`timescale 1ns/1ps
module sto_filter #(
	parameter int FILT = sto_pkg::FILT_CYCLES,
	parameter int W = sto_pkg::FILT_W
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// synchronised closed level in, filtered closed level out
	input wire logic closed_in,
	output logic closed_out
);
	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;
	logic next_closed_out;

	// open must persist past the test pulse; closing is taken at once
	always_comb begin
		next_cnt = '0;
		next_closed_out = closed_out;
		if (closed_in) begin
			next_closed_out = 1'b1;
		end else if (closed_out) begin
			if (cnt >= W'(FILT - 1)) begin
				next_closed_out = 1'b0;
			end else begin
				next_cnt = cnt + W'(1);
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt <= '0;
			closed_out <= 1'b0;
		end else begin
			cnt <= next_cnt;
			closed_out <= next_closed_out;
		end
	end
endmodule

// *** rtl/sto_monitor.sv ***
// What this block does
// - input a open requests torque off
// - input b open requests torque off
// - monitor a conducts while input a off
// - monitor b conducts while input b off
// - both-monitor path conducts only both off
// - either input off shuts base drive
// - release only when both inputs closed
// - off while running: brake stop, alarm
`timescale 1ns/1ps
module sto_monitor #(
	parameter int FILT = sto_pkg::FILT_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// shut-off pins, high when closed
	input wire logic torque_off_input_a,
	input wire logic torque_off_input_b,
	// drive status and alarm clear
	input wire logic motor_running,
	input wire logic alarm_clear,
	// monitor outputs, high when conducting
	output logic shutoff_monitor_out_a,
	output logic shutoff_monitor_out_b,
	output logic shutoff_monitor_both,
	// power stage control
	output logic base_drive_shutoff,
	output logic dynamic_brake,
	output logic shutoff_timing_alarm
);
	sto_pkg::sto_in_t sync1;
	sto_pkg::sto_in_t sync2;
	sto_pkg::sto_in_t filt;
	logic filt_a;
	logic filt_b;
	sto_pkg::sto_mon_t mon;
	sto_pkg::sto_mon_t next_mon;
	logic next_shutoff;
	logic next_alarm;
	logic next_brake;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= '{input_a: torque_off_input_a, input_b: torque_off_input_b};
			sync2 <= sync1;
		end
	end

	sto_filter #(.FILT(FILT), .W(sto_pkg::FILT_W)) u_filt_a (
		.mclk(mclk),
		.rst(rst),
		.closed_in(sync2.input_a),
		.closed_out(filt_a)
	);

	sto_filter #(.FILT(FILT), .W(sto_pkg::FILT_W)) u_filt_b (
		.mclk(mclk),
		.rst(rst),
		.closed_in(sync2.input_b),
		.closed_out(filt_b)
	);

	// one driver for the whole filtered struct
	assign filt = '{input_a: filt_a, input_b: filt_b};

	always_comb begin
		next_mon.mon_a = ~filt.input_a;
		next_mon.mon_b = ~filt.input_b;
		next_mon.mon_both = ~filt.input_a & ~filt.input_b;
		// release needs both closed, else shut off
		next_shutoff = ~(filt.input_a & filt.input_b);
		next_alarm = shutoff_timing_alarm;
		next_brake = dynamic_brake;
		if (alarm_clear & ~next_shutoff) begin
			next_alarm = 1'b0;
			next_brake = 1'b0;
		end
		// event wins over clear
		if (next_shutoff & ~base_drive_shutoff & motor_running) begin
			next_alarm = 1'b1;
			next_brake = 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mon <= '{mon_a: 1'b1, mon_b: 1'b1, mon_both: 1'b1};
			base_drive_shutoff <= sto_pkg::RST_SHUTOFF;
			shutoff_timing_alarm <= sto_pkg::RST_ALARM;
			dynamic_brake <= 1'b0;
		end else begin
			mon <= next_mon;
			base_drive_shutoff <= next_shutoff;
			shutoff_timing_alarm <= next_alarm;
			dynamic_brake <= next_brake;
		end
	end

	assign shutoff_monitor_out_a = mon.mon_a;
	assign shutoff_monitor_out_b = mon.mon_b;
	assign shutoff_monitor_both = mon.mon_both;
endmodule

// *** tb/sto_safety_ctrl.sv ***
`timescale 1ns/1ps
module sto_safety_ctrl (
	// requests
	input wire logic off_a,
	input wire logic off_b,
	input wire logic tp,
	// pins
	output logic torque_off_input_a,
	output logic torque_off_input_b
);
	assign torque_off_input_a = !(off_a || tp);
	assign torque_off_input_b = !off_b;
endmodule

// *** tb/sto_monitor_sva.sv ***
`timescale 1ns/1ps
module sto_chk #(parameter int FILT = 8) (
	// clock, reset, pins
	input wire logic mclk, rst, torque_off_input_a, torque_off_input_b, motor_running,
	// outputs
	input wire logic shutoff_monitor_out_a, shutoff_monitor_out_b, shutoff_monitor_both,
	input wire logic base_drive_shutoff, dynamic_brake, shutoff_timing_alarm
);
	wire a = torque_off_input_a, b = torque_off_input_b, bd = base_drive_shutoff;
	wire ma = shutoff_monitor_out_a, mb = shutoff_monitor_out_b, al = shutoff_timing_alarm;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_both_path: assert property (shutoff_monitor_both == (ma && mb)) else $error("both");
	a_drive_off: assert property (bd == (ma || mb)) else $error("drive");
	a_close_a: assert property ($rose(a) ##1 a[*3] |=> !ma) else $error("close a");
	a_close_b: assert property ($rose(b) ##1 b[*3] |=> !mb) else $error("close b");
	a_open_a: assert property (!a[*8] ##1 !a[*6] |-> ma) else $error("open a");
	a_pulse_hold: assert property (!ma && $fell(a) |-> ##1 !ma[*8]) else $error("pulse");
	a_alarm_set: assert property ($rose(bd) && $past(motor_running) |-> al && dynamic_brake)
		else $error("alarm");
	a_alarm_why: assert property ($rose(al) |-> $rose(bd)) else $error("cause");
	cover property ($rose(al));
	cover property ($fell(bd));
	cover property (ma && !mb);
endmodule
bind sto_monitor sto_chk #(.FILT(FILT)) i_chk (.*);

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
	logic mclk = 0, rst = 1, oa = 1, ob = 1, tp = 0, run = 0, clr = 0;
	logic a, b, ma, mb, mab, bd, db, al;
	int n_fail = 0, num_checks = 0;
	initial forever #50 mclk = ~mclk;
	sto_safety_ctrl i_ctrl (.off_a(oa), .off_b(ob), .tp(tp),
		.torque_off_input_a(a), .torque_off_input_b(b));
	sto_monitor #(.FILT(8)) i_dut (.mclk(mclk), .rst(rst), .torque_off_input_a(a),
		.torque_off_input_b(b), .motor_running(run), .alarm_clear(clr),
		.shutoff_monitor_out_a(ma), .shutoff_monitor_out_b(mb), .shutoff_monitor_both(mab),
		.base_drive_shutoff(bd), .dynamic_brake(db), .shutoff_timing_alarm(al));
	task w(int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask
	task chk(string s, logic [5:0] e);
		num_checks++;
		if ({ma, mb, mab, bd, db, al} !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", s, e, {ma, mb, mab, bd, db, al});
		end
	endtask
	task t_table(logic x, logic y);
		@(posedge mclk);
		oa <= x;
		ob <= y;
		w(14);
		chk("state", {x, y, x & y, x | y, 2'h0});
	endtask
	task t_pulse;
		@(posedge mclk);
		tp <= 1;
		repeat (6) @(posedge mclk);
		tp <= 0;
		w(14);
		chk("pulse", 6'h00);
	endtask
	task t_alarm;
		@(posedge mclk);
		run <= 1;
		oa <= 1;
		ob <= 1;
		w(14);
		chk("alarm", 6'h3f);
		@(posedge mclk);
		run <= 0;
		clr <= 1;
		@(posedge mclk);
		clr <= 0;
		w(2);
		chk("no clear in off", 6'h3f);
		@(posedge mclk);
		oa <= 0;
		ob <= 0;
		repeat (6) @(posedge mclk);
		clr <= 1;
		@(posedge mclk);
		clr <= 0;
		w(2);
		chk("clear", 6'h00);
	endtask
	task wrap_up;
		if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge mclk);
		rst <= 0;
		w(1);
		chk("reset", 6'h3c);
		for (int i = 3; i >= 0; i--) t_table(i[1], i[0]);
		t_pulse;
		t_alarm;
		wrap_up;
	end
endmodule
